//--- verilog/ee2k_consts.vh
/*
 * Constants for the two-wire 256 x 8 serial memory slave: array geometry,
 * page size, write-cycle timing, buffer size and slave-address field layout.
 * Assumes it is included by bare name from every file that needs it.
 */
`ifndef EE2K_CONSTS_VH
`define EE2K_CONSTS_VH

// array geometry
`define EE_ADDR_W 8
`define EE_DATA_W 8
`define EE_WORDS 256
// page buffer, eight bytes
`define EE_PAGE_W 3
`define EE_PAGE_BYTES 8
// erased cell value
`define EE_ERASED 8'hFF
// longest write-cycle time and clock rate
`define EE_TWR_US 10000
`define EE_CLK_MHZ 25
// whole microseconds times whole MHz gives whole cycles with no rounding
`define EE_TWR_CYC (`EE_TWR_US * `EE_CLK_MHZ)
// slave address fields
`define EE_SA_TYPE_HI 7
`define EE_SA_TYPE_LO 4
`define EE_SA_CS_HI 3
`define EE_SA_CS_LO 1
`define EE_SA_RW 0
// write buffer between page and array
`define EE_FIFO_DEPTH 16
`define EE_FIFO_W 16

`endif

//--- verilog/ee2k_fifo.v
/*
 * Synchronous FIFO with valid/ready on both sides; width and depth are
 * parameters. Assumes one clock, async active-low reset, and a clock
 * enable that freezes all state while low.
 */
`timescale 1ns/10ps
module ee2k_fifo #(
    parameter W = 16,
    parameter D = 16
) (
    input wire clk,
    input wire arst_n,
    input wire ce,
    input wire in_valid,
    output wire in_ready,
    input wire [W-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [W-1:0] out_data
);
    // pointer width from depth
    function integer ee_clog2;
        input integer v;
        integer i;
        begin
            ee_clog2 = 1;
            for (i = 2; i < v; i = i * 2) begin
                ee_clog2 = ee_clog2 + 1;
            end
        end
    endfunction

    localparam AW = ee_clog2(D);

    reg [W-1:0] mem_r [0:D-1];
    reg [AW-1:0] wp_r;
    reg [AW-1:0] rp_r;
    reg [AW:0] cnt_r;
    wire push;
    wire pop;

    // honest full and empty from the occupancy count
    assign in_ready = (cnt_r != D[AW:0]);
    assign out_valid = (cnt_r != {(AW+1){1'b0}});
    assign out_data = mem_r[rp_r];
    assign push = in_valid && in_ready && ce;
    assign pop = out_valid && out_ready && ce;

    // storage, no reset needed on data
    always @(posedge clk) begin
        if (push) begin
            mem_r[wp_r] <= in_data;
        end
    end

    // pointers wrap at depth, which need not be a power of two
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wp_r <= {AW{1'b0}};
            rp_r <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wp_r <= (wp_r == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= (rp_r == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_r + 1'b1;
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop && !push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule

//--- verilog/ee2k_array.v
/*
 * The 256 x 8 cell array in flip-flops. Each accepted write first erases
 * the cell, then programs it, so it accepts at most one write every two
 * cycles. Assumes one clock, async reset, clock enable.
 */
`timescale 1ns/10ps
`include "ee2k_consts.vh"
module ee2k_array #(
    parameter AW = `EE_ADDR_W,
    parameter DW = `EE_DATA_W
) (
    input wire clk,
    input wire arst_n,
    input wire ce,
    input wire wr_valid,
    output wire wr_ready,
    input wire [AW-1:0] wr_addr,
    input wire [DW-1:0] wr_data,
    output wire idle,
    input wire [AW-1:0] rd_addr,
    output wire [DW-1:0] rd_data
);
    reg [DW-1:0] cell_r [0:(1<<AW)-1];
    reg prog_r;
    reg [AW-1:0] paddr_r;
    reg [DW-1:0] pdata_r;

    // program phase blocks the next write, giving back-pressure to the fifo
    assign wr_ready = !prog_r;
    assign idle = !prog_r;
    assign rd_data = cell_r[rd_addr];

    // erase then program; cells are kept across reset like real storage
    always @(posedge clk) begin
        if (ce) begin
            if (wr_valid && !prog_r) begin
                cell_r[wr_addr] <= `EE_ERASED;
            end else if (prog_r) begin
                cell_r[paddr_r] <= pdata_r;
            end
        end
    end

    // phase control
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prog_r <= 1'b0;
            paddr_r <= {AW{1'b0}};
            pdata_r <= {DW{1'b0}};
        end else if (ce) begin
            if (wr_valid && !prog_r) begin
                prog_r <= 1'b1;
                paddr_r <= wr_addr;
                pdata_r <= wr_data;
            end else begin
                prog_r <= 1'b0;
            end
        end
    end
endmodule

//--- verilog/ee2k_slave.v
/*
 * Two-wire bus slave for a 256 x 8 nonvolatile array with 8-byte page
 * write, write-protect pin and self-timed write cycle.
 * Assumes scl_i and sda_i are already synchronous to clk and that clk is
 * far faster than the bus clock; sda is open drain, resolved outside.
 */
`timescale 1ns/10ps
`include "ee2k_consts.vh"
module ee2k_slave #(
    parameter TWR_CYC = `EE_TWR_CYC,
    parameter [3:0] TYPE_CODE = 4'h6, // arbitrary value, set per system
    parameter FIFO_DEPTH = `EE_FIFO_DEPTH
) (
    input wire clk,
    input wire arst_n,
    input wire ce,
    input wire scl_i,
    input wire sda_i,
    output wire sda_o,
    output wire sda_oe,
    input wire chip_select_bit0,
    input wire chip_select_bit1,
    input wire chip_select_bit2,
    input wire wp,
    output wire busy
);
    // bus states, one-hot
    localparam [6:0] S_IDLE = 7'h01;
    localparam [6:0] S_RX = 7'h02;
    localparam [6:0] S_ACK = 7'h04;
    localparam [6:0] S_TX = 7'h08;
    localparam [6:0] S_MACK = 7'h10;
    localparam [6:0] S_DROP = 7'h20;
    localparam [6:0] S_TXLD = 7'h40;
    // kind of byte being received
    localparam [1:0] K_DEV = 2'h0;
    localparam [1:0] K_WORD = 2'h1;
    localparam [1:0] K_DATA = 2'h2;

    reg [6:0] st_r;
    reg [1:0] kind_r;
    reg scl_q_r;
    reg sda_q_r;
    reg [7:0] sh_r;
    reg [2:0] bit_r;
    reg ack_r;
    reg oe_r;
    reg rw_r;
    reg mack_r;
    reg [7:0] ptr_r;
    reg [7:0] txsh_r;
    reg [7:0] pg_data_r [0:`EE_PAGE_BYTES-1];
    reg [7:0] pg_vld_r;
    reg [4:0] pg_base_r;
    reg busy_r;
    reg push_go_r;
    reg [2:0] push_idx_r;
    reg [31:0] twr_cnt_r;
    reg [7:0] pg_vld_snap_r;
    reg [7:0] pg_snap_data_r [0:`EE_PAGE_BYTES-1];
    reg [4:0] snap_base_r;
    wire scl_rise;
    wire scl_fall;
    wire start_cond;
    wire stop_cond;
    wire [7:0] byte_in;
    wire addr_match;
    wire fifo_in_ready;
    wire fifo_in_valid;
    wire fifo_out_valid;
    wire fifo_out_ready;
    wire [15:0] fifo_out_data;
    wire arr_ready;
    wire arr_idle;
    wire [7:0] rd_data;
    wire twr_done;
    integer i;
    integer j;

    // in-page increment: low three bits wrap, page base kept
    function [7:0] ee_page_inc;
        input [7:0] a;
        begin
            ee_page_inc = {a[7:3], a[2:0] + 3'h1};
        end
    endfunction

    // edges of the master clock and line events; the master owns scl
    assign scl_rise = scl_i && !scl_q_r;
    assign scl_fall = !scl_i && scl_q_r;
    assign start_cond = scl_i && scl_q_r && sda_q_r && !sda_i;
    assign stop_cond = scl_i && scl_q_r && !sda_q_r && sda_i;
    assign byte_in = {sh_r[6:0], sda_i};

    // type code and all three select pins must match
    assign addr_match = (byte_in[`EE_SA_TYPE_HI:`EE_SA_TYPE_LO] == TYPE_CODE) &&
        (byte_in[`EE_SA_CS_HI:`EE_SA_CS_LO] == {chip_select_bit2, chip_select_bit1, chip_select_bit0});

    // open drain: output level is always low, only the enable moves
    assign sda_o = 1'b0;
    assign sda_oe = oe_r;
    assign busy = busy_r;

    // serial engine
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= S_IDLE;
            kind_r <= K_DEV;
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
            sh_r <= 8'h00;
            bit_r <= 3'h0;
            ack_r <= 1'b0;
            oe_r <= 1'b0;
            rw_r <= 1'b0;
            mack_r <= 1'b0;
            ptr_r <= 8'h00;
            txsh_r <= 8'hFF;
            pg_vld_r <= 8'h00;
            pg_base_r <= 5'h00;
            for (i = 0; i < `EE_PAGE_BYTES; i = i + 1) begin
                pg_data_r[i] <= 8'h00;
            end
        end else if (ce) begin
            scl_q_r <= scl_i;
            sda_q_r <= sda_i;
            if (start_cond) begin
                // repeated start drops any uncommitted page
                st_r <= S_RX;
                kind_r <= K_DEV;
                bit_r <= 3'h0;
                oe_r <= 1'b0;
                pg_vld_r <= 8'h00;
            end else if (stop_cond) begin
                st_r <= S_IDLE;
                oe_r <= 1'b0;
                pg_vld_r <= 8'h00; // handed to the programmer below
            end else begin
                case (st_r)
                    S_RX: begin
                        if (scl_rise) begin
                            sh_r <= byte_in;
                            bit_r <= bit_r + 3'h1;
                            if (bit_r == 3'h7) begin
                                case (kind_r)
                                    K_DEV: ack_r <= addr_match && !busy_r;
                                    K_WORD: ack_r <= 1'b1;
                                    default: ack_r <= !wp;
                                endcase
                                st_r <= S_ACK;
                            end
                        end
                    end
                    S_ACK: begin
                        // pull low for the ninth clock only when accepting
                        if (scl_fall && !oe_r) begin
                            oe_r <= ack_r;
                            if (!ack_r) begin
                                st_r <= S_DROP;
                            end
                        end else if (scl_fall && oe_r) begin
                            oe_r <= 1'b0;
                            bit_r <= 3'h0;
                            st_r <= S_RX;
                            case (kind_r)
                                K_DEV: begin
                                    rw_r <= sh_r[`EE_SA_RW];
                                    kind_r <= K_WORD;
                                    if (sh_r[`EE_SA_RW]) begin
                                        st_r <= S_TXLD;
                                    end
                                end
                                K_WORD: begin
                                    ptr_r <= sh_r;
                                    pg_base_r <= sh_r[7:3];
                                    kind_r <= K_DATA;
                                end
                                default: begin
                                    // store in page slot, wrap past eight
                                    pg_data_r[ptr_r[2:0]] <= sh_r;
                                    pg_vld_r[ptr_r[2:0]] <= 1'b1;
                                    ptr_r <= ee_page_inc(ptr_r);
                                end
                            endcase
                        end
                    end
                    S_TXLD: begin
                        // ack clock already released; drive first bit now
                        txsh_r <= {rd_data[6:0], 1'b1};
                        oe_r <= !rd_data[7];
                        ptr_r <= ptr_r + 8'h01;
                        bit_r <= 3'h0;
                        st_r <= S_TX;
                    end
                    S_TX: begin
                        if (scl_fall) begin
                            if (bit_r == 3'h7) begin
                                oe_r <= 1'b0;
                                st_r <= S_MACK;
                            end else begin
                                oe_r <= !txsh_r[7];
                                txsh_r <= {txsh_r[6:0], 1'b1};
                                bit_r <= bit_r + 3'h1;
                            end
                        end
                    end
                    S_MACK: begin
                        if (scl_rise) begin
                            mack_r <= !sda_i;
                        end else if (scl_fall) begin
                            st_r <= mack_r ? S_TXLD : S_DROP;
                        end
                    end
                    S_DROP: begin
                        oe_r <= 1'b0;
                    end
                    default: begin
                        oe_r <= 1'b0;
                    end
                endcase
            end
        end
    end

    // programming control: stop commits the page and starts the timed cycle
    assign twr_done = (twr_cnt_r == 32'h0);
    assign fifo_in_valid = push_go_r && pg_vld_snap_r[push_idx_r];

    // own loop index, so the serial engine's index keeps a single driver
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            busy_r <= 1'b0;
            push_go_r <= 1'b0;
            push_idx_r <= 3'h0;
            twr_cnt_r <= 32'h0;
            pg_vld_snap_r <= 8'h00;
            snap_base_r <= 5'h00;
            for (j = 0; j < `EE_PAGE_BYTES; j = j + 1) begin
                pg_snap_data_r[j] <= 8'h00;
            end
        end else if (ce) begin
            if (stop_cond && !busy_r && (pg_vld_r != 8'h00)) begin
                // protected writes never filled the page, so never start
                busy_r <= 1'b1;
                push_go_r <= 1'b1;
                push_idx_r <= 3'h0;
                twr_cnt_r <= TWR_CYC - 1;
                pg_vld_snap_r <= pg_vld_r;
                snap_base_r <= pg_base_r;
                for (j = 0; j < `EE_PAGE_BYTES; j = j + 1) begin
                    pg_snap_data_r[j] <= pg_data_r[j];
                end
            end else if (busy_r) begin
                if (!twr_done) begin
                    twr_cnt_r <= twr_cnt_r - 32'h1;
                end
                if (push_go_r && (!fifo_in_valid || fifo_in_ready)) begin
                    push_idx_r <= push_idx_r + 3'h1;
                    if (push_idx_r == 3'h7) begin
                        push_go_r <= 1'b0;
                    end
                end
                // busy holds for the full cycle time and until cells settle
                if (twr_done && !push_go_r && !fifo_out_valid && arr_idle) begin
                    busy_r <= 1'b0;
                end
            end
        end
    end

    // array drains the buffer only during the write cycle
    assign fifo_out_ready = arr_ready && busy_r;

    ee2k_fifo #(
        .W(`EE_FIFO_W),
        .D(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .arst_n(arst_n),
        .ce(ce),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data({snap_base_r, push_idx_r, pg_snap_data_r[push_idx_r]}),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    ee2k_array #(
        .AW(`EE_ADDR_W),
        .DW(`EE_DATA_W)
    ) u_array (
        .clk(clk),
        .arst_n(arst_n),
        .ce(ce),
        .wr_valid(fifo_out_valid && busy_r),
        .wr_ready(arr_ready),
        .wr_addr(fifo_out_data[15:8]),
        .wr_data(fifo_out_data[7:0]),
        .idle(arr_idle),
        .rd_addr(ptr_r),
        .rd_data(rd_data)
    );
endmodule

//--- test/ee2k_slave_checker.sv
/* checker for the two-wire memory slave, bound to its top module.
   assumes one clock domain and the async active-low reset. */
`timescale 1ns/10ps
module ee2k_slave_checker #(
    parameter TWR_CYC = 300
) (
    input wire clk,
    input wire arst_n,
    input wire ce,
    input wire scl_i,
    input wire sda_i,
    input wire sda_o,
    input wire sda_oe,
    input wire wp,
    input wire busy
);
    reg scl_q, sda_q, wp_low_r;
    reg [7:0] low_cnt;
    reg [31:0] busy_cnt;
    // bus history, clock-low age, busy length, protect seen low since start
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            wp_low_r <= 1'b0;
            low_cnt <= 8'h00;
            busy_cnt <= 32'h0000_0000;
        end else begin
            scl_q <= scl_i;
            sda_q <= sda_i;
            low_cnt <= scl_i ? 8'h00 : (low_cnt == 8'hFF ? low_cnt : low_cnt + 8'h01);
            // a frozen clock enable also freezes the write-cycle timer
            if (ce)
                busy_cnt <= busy ? busy_cnt + 32'h0000_0001 : 32'h0000_0000;
            if (scl_i && scl_q && sda_q && !sda_i)
                wp_low_r <= !wp;
            else if (!wp)
                wp_low_r <= 1'b1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    property p_od; sda_o == 1'b0; endproperty
    a_od: assert property (p_od) else $error("data line driven high");
    property p_still; $changed(sda_oe) |-> !scl_i && !$past(scl_i); endproperty
    a_still: assert property (p_still) else $error("data moved with clock high");
    property p_ack_lat; $rose(sda_oe) |-> low_cnt >= 8'h01 && low_cnt <= 8'h03; endproperty
    a_ack_lat: assert property (p_ack_lat) else $error("pull-down at wrong time");
    property p_quiet; busy |-> !sda_oe; endproperty
    a_quiet: assert property (p_quiet) else $error("answered while busy");
    property p_stop; $rose(busy) |-> scl_i && sda_i; endproperty
    a_stop: assert property (p_stop) else $error("busy without stop");
    property p_wp; $rose(busy) |-> wp_low_r; endproperty
    a_wp: assert property (p_wp) else $error("programmed while protected");
    property p_busy_min; $fell(busy) |-> busy_cnt >= TWR_CYC - 1; endproperty
    a_busy_min: assert property (p_busy_min) else $error("write cycle too short");
    property p_busy_max; busy_cnt <= TWR_CYC + 64; endproperty
    a_busy_max: assert property (p_busy_max) else $error("write cycle too long");
endmodule
bind ee2k_slave ee2k_slave_checker #(.TWR_CYC(TWR_CYC)) ee2k_slave_checker_i (.clk(clk), .arst_n(arst_n), .ce(ce),
    .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .wp(wp), .busy(busy));

//--- test/ee2k_i2c_master.sv
/* two-wire bus master model: makes the bus clock, pulls data low.
   assumes a pull-up on the data line, resolved by the bench. */
`timescale 1ns/10ps
module ee2k_i2c_master (
    input wire clk,
    input wire sda,
    output reg scl,
    output reg pull
);
    // idle bus: clock high, data released
    initial begin
        scl = 1'b1;
        pull = 1'b0;
    end
    task cyc(input integer n);
        repeat (n) @(posedge clk);
    endtask
    // data only moves with the clock low; high and low last 4 cycles
    task bit_io(input b, output r);
        pull <= !b;
        cyc(2);
        scl <= 1'b1;
        cyc(4);
        r = sda;
        scl <= 1'b0;
        cyc(2);
    endtask
    task start;
        pull <= 1'b0;
        cyc(2);
        scl <= 1'b1;
        cyc(4);
        pull <= 1'b1;
        cyc(4);
        scl <= 1'b0;
        cyc(2);
    endtask
    task stop;
        pull <= 1'b1;
        cyc(2);
        scl <= 1'b1;
        cyc(4);
        pull <= 1'b0;
        cyc(4);
    endtask
    // msb first, ninth bit is the acknowledge
    task byte_io(input [7:0] tx, input m_ack, output [7:0] rx, output ack);
        integer i;
        reg a;
        for (i = 7; i >= 0; i = i - 1)
            bit_io(tx[i], rx[i]);
        bit_io(!m_ack, a);
        ack = !a;
    endtask
endmodule

//--- test/ee2k_slave_bench.sv
/* self-checking bench for the two-wire memory slave.
   assumes the master model drives the bus; data line has a pull-up. */
`timescale 1ns/10ps
module ee2k_slave_bench;
    localparam [3:0] DEV_TYPE = 4'h6; // arbitrary value
    localparam integer TWR = 300;
    reg clk, arst_n, wp, ack, ce_r;
    reg [2:0] cs_r;
    reg [7:0] rx, pa, d;
    reg [7:0] mem [0:255];
    integer mismatches, tests_run, cycles, seed, r;
    wire scl, pull, sda_o, sda_oe, busy, sda_w;
    // open drain: anyone pulling wins, else pull-up
    assign sda_w = pull ? 1'b0 : (sda_oe ? sda_o : 1'b1);
    ee2k_slave #(.TWR_CYC(TWR), .TYPE_CODE(DEV_TYPE)) ee2k_slave_i (.clk(clk), .arst_n(arst_n), .ce(ce_r),
        .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .chip_select_bit0(cs_r[0]),
        .chip_select_bit1(cs_r[1]), .chip_select_bit2(cs_r[2]), .wp(wp), .busy(busy));
    ee2k_i2c_master ee2k_i2c_master_i (.clk(clk), .sda(sda_w), .scl(scl), .pull(pull));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // hang guard, well above the expected run
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 60000) begin
            mismatches = mismatches + 1;
            wrap_up;
        end
    end
    task wrap_up;
        if (mismatches == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task check(input [7:0] seen, input [7:0] exp);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("[ERR] %0t got %h want %h", $time, seen, exp);
        end
    endtask
    function [7:0] dev(input rw);
        dev = {DEV_TYPE, cs_r, rw};
    endfunction
    // page offset wraps, page number stays
    function [7:0] slot(input [7:0] a, input integer i);
        slot = {a[7:3], a[2:0] + i[2:0]};
    endfunction
    task xb(input [7:0] tx, input m_ack);
        ee2k_i2c_master_i.byte_io(tx, m_ack, rx, ack);
    endtask
    // protected writes send one byte only: the slave ignores the rest
    task write_seq(input [7:0] a, input integer n, input prot);
        integer i;
        ee2k_i2c_master_i.start;
        xb(dev(1'b0), 1'b0);
        check(ack, 1);
        xb(a, 1'b0);
        check(ack, 1);
        for (i = 0; i < n; i = i + 1) begin
            d = $random(seed);
            xb(d, 1'b0);
            check(ack, !prot);
            if (!prot)
                mem[slot(a, i)] = d;
        end
        ee2k_i2c_master_i.stop;
        check(busy, !prot);
        if (!prot) begin
            // clock enable low must hold the write cycle where it stands
            ce_r <= 1'b0;
            repeat (2 * TWR) @(posedge clk);
            check(busy, 1);
            ce_r <= 1'b1;
            ee2k_i2c_master_i.start;
            xb(dev(1'b0), 1'b0);
            check(ack, 0);
            ee2k_i2c_master_i.stop;
            wait_idle;
        end
    endtask
    task wait_idle;
        integer k;
        k = 0;
        while (busy !== 1'b0 && k < 2 * TWR) begin
            @(posedge clk);
            k = k + 1;
        end
        check(k < 2 * TWR, 1);
    endtask
    // random read: set pointer, repeated start, sequential bytes
    task read_seq(input [7:0] a, input integer n);
        integer i;
        reg [7:0] p;
        ee2k_i2c_master_i.start;
        xb(dev(1'b0), 1'b0);
        xb(a, 1'b0);
        ee2k_i2c_master_i.start;
        xb(dev(1'b1), 1'b0);
        check(ack, 1);
        for (i = 0; i < n; i = i + 1) begin
            p = a + i[7:0];
            xb(8'hFF, i < n - 1);
            check(rx, mem[p]);
        end
        ee2k_i2c_master_i.stop;
    endtask
    initial begin
        seed = 32'hD960;
        mismatches = 0;
        tests_run = 0;
        cycles = 0;
        arst_n = 1'b0;
        ce_r <= 1'b1;
        wp <= 1'b0;
        cs_r <= $random(seed);
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge clk);
        // every select code plus a wrong type code; only the strapped one answers
        for (r = 0; r < 9; r = r + 1) begin
            ee2k_i2c_master_i.start;
            xb(r < 8 ? {DEV_TYPE, r[2:0], 1'b0} : {~DEV_TYPE, cs_r, 1'b0}, 1'b0);
            check(ack, r < 8 && r[2:0] == cs_r);
            ee2k_i2c_master_i.stop;
        end
        // byte writes, both array ends among them
        for (r = 0; r < 6; r = r + 1) begin
            pa = r == 0 ? 8'hFF : (r == 1 ? 8'h00 : $random(seed));
            write_seq(pa, 1, 1'b0);
            read_seq(pa, 1);
        end
        // ten bytes from offset six overwrite the first two
        pa = $random(seed);
        pa[2:0] = 3'h6;
        write_seq(pa, 10, 1'b0);
        read_seq({pa[7:3], 3'h0}, 8);
        // protected: data refused, reads still served
        wp <= 1'b1;
        write_seq(pa, 1, 1'b1);
        read_seq({pa[7:3], 3'h0}, 8);
        wp <= 1'b0;
        write_seq(pa, 2, 1'b0);
        read_seq(pa, 2);
        wrap_up;
    end
endmodule
